/* hw/pcs_pipeline_regs.sv */
// control, status and double-buffered timing registers of the pipeline
// Operation
// - clearing the run enable halts a stage; it resets to enabled
// - run enable changes reach the stage only at vertical blank rising edge
// - host sets the update bit; shadows copy to working at next vblank rise
// - update semaphore exists in all stages except gamma
// - writing one to interpolation control bit 2 clears status flags
// - soft reset bit returns stage registers to defaults; it resets to zero
// - outputs held at zero or defaults while soft reset stays set, except working timing, which follows the detector
// - status bit 8 sync seen, bit 9 rows too many, bit 10 columns
// - status bits 11 to 16 flag polarity and count changes in order
// - interrupt control bit 0 global enable, bit 1 clears sources
// - interrupt control bits 8 to 16 let a rising flag request interrupt
// - irq goes high when an enabled flag rises with global enable set
// - column timing fields hold values below the column limit
// - row timing fields hold values below the row limit
// - phase bits 0 and 1 pick horizontal and vertical bayer phase
// - writes to double-buffered registers land in shadows at once
// - working timing follows the detector until the first copy
// - interpolation reset returns working timing to detector values
`timescale 1ns/1ps
module pcs_pipeline_regs (
    input  wire logic                      mclk,
    input  wire logic                      rst,
    input  wire logic [11:0]               paddr,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire logic                      vblank_in,
    input  wire logic                      det_vsync_seen,
    input  wire logic                      det_vblank_pol,
    input  wire logic                      det_hblank_pol,
    input  wire logic [pcs_pkg::MEAS_W-1:0] det_total_rows,
    input  wire logic [pcs_pkg::MEAS_W-1:0] det_total_cols,
    input  wire logic [pcs_pkg::MEAS_W-1:0] det_blank_rows,
    input  wire logic [pcs_pkg::MEAS_W-1:0] det_blank_cols,
    input  wire logic [pcs_pkg::TIM_W-1:0]  meas_timing [pcs_pkg::NUM_TIMING],
    output logic      [pcs_pkg::TIM_W-1:0]  work_timing [pcs_pkg::NUM_TIMING],
    output logic      [3:0]                stage_run,
    output logic      [3:0]                stage_hold,
    output logic      [3:0]                stage_commit,
    output logic                           bayer_phase_x,
    output logic                           bayer_phase_y,
    output logic                           irq
);
    localparam int NT = pcs_pkg::NUM_TIMING;
    localparam int TW = pcs_pkg::TIM_W;
    localparam int SI = pcs_pkg::STG_INTERP;

    function automatic logic stage_hit(input logic [11:0] a, input int s,
                                       input logic [11:0] ofs);
        return a == (12'(s) * pcs_pkg::OFS_STAGE_STRIDE + ofs);
    endfunction : stage_hit

    // timing register index, or 15 when the address holds none
    function automatic logic [3:0] tim_index(input logic [11:0] a);
        logic [11:0] rel;
        rel = a - pcs_pkg::OFS_TIMING_BASE;
        if (a >= pcs_pkg::OFS_TIMING_BASE && rel < 12'(NT * 4) && a[1:0] == 2'h0) begin
            return 4'(rel >> 2);
        end
        return 4'hF;
    endfunction : tim_index

    logic            vb_s1_ff, vb_s2_ff, vb_s3_ff, vb_rise;
    logic            pready_ff, pslverr_ff;
    logic [31:0]     prdata_ff, rd_data;
    logic            rd_err, wr_en;
    logic [3:0]      wr_tim;
    logic [3:0]      ctl_wr, srst_wr, ctl_en, ctl_upd, srst, run, commit;
    logic            clear_cmd, isrst;
    logic [8:0]      st_ff, ev, rise, mask_ff;
    logic            int_en_ff, irq_ff;
    logic [1:0]      phase_sh_ff, phase_wk_ff;
    logic [TW-1:0]   shadow_ff [NT];
    logic [TW-1:0]   work_ff [NT];
    logic            use_host_ff;
    logic            prev_valid_ff, vpol_prev_ff, hpol_prev_ff;
    logic [pcs_pkg::MEAS_W-1:0] trows_prev_ff, tcols_prev_ff, brows_prev_ff, bcols_prev_ff;

    // vblank comes from the pin domain, only the second and third stages are looked at
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            vb_s1_ff <= 1'b0;
            vb_s2_ff <= 1'b0;
            vb_s3_ff <= 1'b0;
        end else begin
            vb_s1_ff <= vblank_in;
            vb_s2_ff <= vb_s1_ff;
            vb_s3_ff <= vb_s2_ff;
        end
    end
    assign vb_rise = vb_s2_ff & ~vb_s3_ff;

    // apb: one wait-free access phase; answer prepared during setup
    assign wr_en  = psel & penable & pwrite & pready_ff;
    assign wr_tim = tim_index(paddr);

    always_comb begin
        rd_data = 32'h0000_0000;
        rd_err  = 1'b0;
        if (wr_tim != 4'hF) begin
            rd_data[TW-1:0] = shadow_ff[wr_tim];
        end else if (paddr == pcs_pkg::OFS_STATUS) begin
            rd_data[pcs_pkg::ST_HI:pcs_pkg::ST_LO] = st_ff;
        end else if (paddr == pcs_pkg::OFS_INT_CTRL) begin
            rd_data[pcs_pkg::INT_EN_BIT] = int_en_ff;
            rd_data[pcs_pkg::ST_HI:pcs_pkg::ST_LO] = mask_ff;
        end else if (paddr == pcs_pkg::OFS_PHASE) begin
            rd_data[1:0] = phase_sh_ff;
        end else begin
            rd_err = 1'b1;
            for (int s = 0; s < pcs_pkg::NUM_STAGES; s++) begin
                if (stage_hit(paddr, s, pcs_pkg::OFS_CONTROL)) begin
                    rd_data[pcs_pkg::CTL_RUN_BIT]    = ctl_en[s];
                    rd_data[pcs_pkg::CTL_UPDATE_BIT] = ctl_upd[s];
                    rd_err = 1'b0;
                end
                if (stage_hit(paddr, s, pcs_pkg::OFS_SOFT_RESET)) begin
                    rd_data[pcs_pkg::SRST_BIT] = srst[s];
                    rd_err = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
        end else begin
            pready_ff  <= psel & ~penable;
            pslverr_ff <= psel & ~penable & rd_err;
            if (psel & ~penable & ~pwrite) begin
                prdata_ff <= rd_data;
            end
        end
    end

    // stage control blocks; gamma has no write-done semaphore
    generate
        for (genvar s = 0; s < pcs_pkg::NUM_STAGES; s++) begin : g_stage
            assign ctl_wr[s]  = wr_en & stage_hit(paddr, s, pcs_pkg::OFS_CONTROL);
            assign srst_wr[s] = wr_en & stage_hit(paddr, s, pcs_pkg::OFS_SOFT_RESET);
            pcs_stage_ctl #(
                .HAS_UPDATE (s != pcs_pkg::STG_GAMMA)
            ) u_ctl (
                .mclk        (mclk),
                .rst         (rst),
                .vblank_rise (vb_rise),
                .ctl_wr      (ctl_wr[s]),
                .srst_wr     (srst_wr[s]),
                .wdata       (pwdata),
                .enable_ff   (ctl_en[s]),
                .update_ff   (ctl_upd[s]),
                .soft_rst_ff (srst[s]),
                .run_ff      (run[s]),
                .commit_ff   (commit[s])
            );
        end
    endgenerate

    assign isrst     = srst[SI];
    assign clear_cmd = (ctl_wr[SI] & pwdata[pcs_pkg::CTL_CLEAR_BIT])
                     | (wr_en & (paddr == pcs_pkg::OFS_INT_CTRL)
                        & pwdata[pcs_pkg::INT_CLR_BIT]);

    // detector history for change flags; first sample after reset is no change
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            prev_valid_ff <= 1'b0;
            vpol_prev_ff  <= 1'b0;
            hpol_prev_ff  <= 1'b0;
            trows_prev_ff <= '0;
            tcols_prev_ff <= '0;
            brows_prev_ff <= '0;
            bcols_prev_ff <= '0;
        end else begin
            prev_valid_ff <= ~isrst;
            vpol_prev_ff  <= det_vblank_pol;
            hpol_prev_ff  <= det_hblank_pol;
            trows_prev_ff <= det_total_rows;
            tcols_prev_ff <= det_total_cols;
            brows_prev_ff <= det_blank_rows;
            bcols_prev_ff <= det_blank_cols;
        end
    end

    always_comb begin
        ev    = 9'h000;
        ev[0] = det_vsync_seen;
        ev[1] = det_total_rows > pcs_pkg::MEAS_W'(pcs_pkg::MAX_ROWS);
        ev[2] = det_total_cols > pcs_pkg::MEAS_W'(pcs_pkg::MAX_COLS);
        if (prev_valid_ff) begin
            ev[3] = det_vblank_pol != vpol_prev_ff;
            ev[4] = det_hblank_pol != hpol_prev_ff;
            ev[5] = det_total_rows != trows_prev_ff;
            ev[6] = det_total_cols != tcols_prev_ff;
            ev[7] = det_blank_rows != brows_prev_ff;
            ev[8] = det_blank_cols != bcols_prev_ff;
        end
    end
    assign rise = ev & ~st_ff;

    // sticky flags; a new event in the clear cycle survives the clear
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_ff <= pcs_pkg::RST_STATUS;
        end else if (isrst) begin
            st_ff <= pcs_pkg::RST_STATUS;
        end else begin
            st_ff <= ev | (clear_cmd ? 9'h000 : st_ff);
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            int_en_ff <= pcs_pkg::RST_INT_EN;
            mask_ff   <= pcs_pkg::RST_INT_MASK;
        end else if (isrst) begin
            int_en_ff <= pcs_pkg::RST_INT_EN;
            mask_ff   <= pcs_pkg::RST_INT_MASK;
        end else if (wr_en && paddr == pcs_pkg::OFS_INT_CTRL) begin
            int_en_ff <= pwdata[pcs_pkg::INT_EN_BIT];
            mask_ff   <= pwdata[pcs_pkg::ST_HI:pcs_pkg::ST_LO];
        end
    end

    // only a fresh rise interrupts, so an uncleared flag cannot re-trigger
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            irq_ff <= 1'b0;
        end else if (isrst) begin
            irq_ff <= 1'b0;
        end else if (int_en_ff && (rise & mask_ff) != 9'h000) begin
            irq_ff <= 1'b1;
        end else if (clear_cmd) begin
            irq_ff <= 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            phase_sh_ff <= pcs_pkg::RST_PHASE;
            phase_wk_ff <= pcs_pkg::RST_PHASE;
        end else if (isrst) begin
            phase_sh_ff <= pcs_pkg::RST_PHASE;
            phase_wk_ff <= pcs_pkg::RST_PHASE;
        end else begin
            if (wr_en && paddr == pcs_pkg::OFS_PHASE) begin
                phase_sh_ff <= pwdata[1:0];
            end
            if (commit[SI]) begin
                phase_wk_ff <= phase_sh_ff;
            end
        end
    end

    // fields are masked to the limit width, limits being powers of two
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NT; i++) begin
                shadow_ff[i] <= pcs_pkg::RST_TIM;
            end
        end else if (isrst) begin
            for (int i = 0; i < NT; i++) begin
                shadow_ff[i] <= pcs_pkg::RST_TIM;
            end
        end else if (wr_en && wr_tim != 4'hF) begin
            shadow_ff[wr_tim] <= pwdata[TW-1:0] & (pcs_pkg::ROW_FIELDS[wr_tim]
                                 ? pcs_pkg::ROW_MASK : pcs_pkg::COL_MASK);
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            use_host_ff <= 1'b0;
        end else if (isrst) begin
            use_host_ff <= 1'b0;
        end else if (commit[SI]) begin
            use_host_ff <= 1'b1;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NT; i++) begin
                work_ff[i] <= pcs_pkg::RST_TIM;
            end
        end else begin
            for (int i = 0; i < NT; i++) begin
                if (commit[SI]) begin
                    work_ff[i] <= shadow_ff[i];
                end else if (!use_host_ff || isrst) begin
                    work_ff[i] <= meas_timing[i];
                end
            end
        end
    end

    assign prdata        = prdata_ff;
    assign pready        = pready_ff;
    assign pslverr       = pslverr_ff;
    assign work_timing   = work_ff;
    assign stage_run     = run;
    assign stage_hold    = srst;
    assign stage_commit  = commit;
    assign bayer_phase_x = phase_wk_ff[pcs_pkg::PHASE_X_BIT];
    assign bayer_phase_y = phase_wk_ff[pcs_pkg::PHASE_Y_BIT];
    assign irq           = irq_ff;

    run_enable_a: assert property (@(posedge mclk) disable iff (rst)
        vb_rise && !ctl_en[SI] && !isrst |=> !stage_run[SI])
        else $error("stage kept running after disable at vblank");
    run_edge_a: assert property (@(posedge mclk) disable iff (rst)
        $changed(stage_run[SI]) |-> $past(vb_rise) || $past(isrst))
        else $error("run enable changed mid frame");
    commit_copy_a: assert property (@(posedge mclk) disable iff (rst)
        stage_commit[SI] |=> work_timing[4] == $past(shadow_ff[4]) && use_host_ff)
        else $error("shadow not copied on commit");
    gamma_nosema_a: assert property (@(posedge mclk) disable iff (rst)
        !ctl_upd[pcs_pkg::STG_GAMMA] && !stage_commit[pcs_pkg::STG_GAMMA])
        else $error("gamma stage shows a semaphore");
    status_clear_a: assert property (@(posedge mclk) disable iff (rst)
        clear_cmd && ev == 9'h000 |=> st_ff == 9'h000)
        else $error("status flags not cleared");
    soft_hold_a: assert property (@(posedge mclk) disable iff (rst)
        isrst [*2] |-> !stage_run[SI] && !irq && st_ff == 9'h000)
        else $error("outputs not held during soft reset");
    irq_raise_a: assert property (@(posedge mclk) disable iff (rst)
        int_en_ff && (rise & mask_ff) != 9'h000 && !isrst |=> irq ##1 (irq || clear_cmd))
        else $error("enabled flag rise did not raise irq");
    flag_sticky_a: assert property (@(posedge mclk) disable iff (rst)
        st_ff[0] && !clear_cmd && !isrst |=> st_ff[0])
        else $error("status flag dropped without clear");
    follow_meas_a: assert property (@(posedge mclk) disable iff (rst)
        !use_host_ff && !commit[SI] |=> work_timing[0] == $past(meas_timing[0]))
        else $error("working timing not following detector");
    host_write_a: assert property (@(posedge mclk) disable iff (rst)
        wr_en && wr_tim == 4'h0 && !isrst |=> shadow_ff[0] == $past(pwdata[TW-1:0]))
        else $error("shadow write lost");

    commit_seen_c: cover property (@(posedge mclk) disable iff (rst) stage_commit[SI]);
    irq_seen_c: cover property (@(posedge mclk) disable iff (rst) $rose(irq) ##[1:50] clear_cmd);
    disable_c: cover property (@(posedge mclk) disable iff (rst) $fell(stage_run[SI]));
endmodule : pcs_pipeline_regs

/* hw/pcs_pkg.sv */
// constants shared by the pipeline control and status register bank
package pcs_pkg;
    // stage numbering
    localparam int NUM_STAGES = 4;
    localparam int STG_DEFECT = 0;
    localparam int STG_INTERP = 1;
    localparam int STG_COLOR  = 2;
    localparam int STG_GAMMA  = 3;

    // register byte offsets
    localparam logic [11:0] OFS_STAGE_STRIDE = 12'h010;
    localparam logic [11:0] OFS_CONTROL      = 12'h000;
    localparam logic [11:0] OFS_SOFT_RESET   = 12'h004;
    localparam logic [11:0] OFS_STATUS       = 12'h040;
    localparam logic [11:0] OFS_INT_CTRL     = 12'h044;
    localparam logic [11:0] OFS_PHASE        = 12'h048;
    localparam logic [11:0] OFS_TIMING_BASE  = 12'h050;

    // control, reset and interrupt control fields
    localparam int CTL_RUN_BIT    = 0;
    localparam int CTL_UPDATE_BIT = 1;
    localparam int CTL_CLEAR_BIT  = 2;
    localparam int SRST_BIT       = 0;
    localparam int INT_EN_BIT     = 0;
    localparam int INT_CLR_BIT    = 1;
    localparam int PHASE_X_BIT    = 0;
    localparam int PHASE_Y_BIT    = 1;

    // status flag positions
    localparam int ST_LO          = 8;
    localparam int ST_HI          = 16;
    localparam int ST_VSYNC       = 8;
    localparam int ST_ROWS_ERR    = 9;
    localparam int ST_COLS_ERR    = 10;
    localparam int ST_VERTICAL_BLANK_POLARITY_CHANGED  = 11;
    localparam int ST_HORIZONTAL_BLANK_POLARITY_CHANGED  = 12;
    localparam int ST_TOTAL_ROW_COUNT_CHANGED   = 13;
    localparam int ST_TOTAL_COLUMN_COUNT_CHANGED   = 14;
    localparam int ST_BLANK_ROW_COUNT_CHANGED   = 15;
    localparam int ST_BLANK_COLUMN_COUNT_CHANGED   = 16;

    // reset values
    localparam logic       RST_RUN_ENABLE = 1'h1;
    localparam logic       RST_UPDATE     = 1'h0;
    localparam logic       RST_SOFT       = 1'h0;
    localparam logic       RST_INT_EN     = 1'h0;
    localparam logic [8:0] RST_INT_MASK   = 9'h000;
    localparam logic [8:0] RST_STATUS     = 9'h000;
    localparam logic [1:0] RST_PHASE      = 2'h0;

    // timing register set; limits must be powers of two
    localparam int MAX_COLS   = 1024;
    localparam int MAX_ROWS   = 1024;
    localparam int TIM_W      = 10;
    localparam int MEAS_W     = 11;
    localparam int NUM_TIMING = 9;
    localparam logic [TIM_W-1:0] COL_MASK  = TIM_W'(MAX_COLS - 1);
    localparam logic [TIM_W-1:0] ROW_MASK  = TIM_W'(MAX_ROWS - 1);
    localparam logic [TIM_W-1:0] RST_TIM   = 10'h000;
    // active_left, active_right, active_top, active_bottom, total_rows,
    // total_cols, blank_rows, blank_left, blank_right: set bit = row field
    localparam logic [NUM_TIMING-1:0] ROW_FIELDS = 9'h05C;
endpackage : pcs_pkg

/* hw/pcs_stage_ctl.sv */
// per-stage run enable, write-done semaphore and soft reset
`timescale 1ns/1ps
module pcs_stage_ctl #(
    parameter bit HAS_UPDATE = 1'b1
) (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        vblank_rise,
    input  wire logic        ctl_wr,
    input  wire logic        srst_wr,
    input  wire logic [31:0] wdata,
    output logic             enable_ff,
    output logic             update_ff,
    output logic             soft_rst_ff,
    output logic             run_ff,
    output logic             commit_ff
);
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            enable_ff <= pcs_pkg::RST_RUN_ENABLE;
        end else if (soft_rst_ff) begin
            enable_ff <= pcs_pkg::RST_RUN_ENABLE;
        end else if (ctl_wr) begin
            enable_ff <= wdata[pcs_pkg::CTL_RUN_BIT];
        end
    end

    // a host write in the vblank cycle wins; the copy uses the old value
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            update_ff <= pcs_pkg::RST_UPDATE;
        end else if (soft_rst_ff) begin
            update_ff <= pcs_pkg::RST_UPDATE;
        end else if (ctl_wr) begin
            update_ff <= HAS_UPDATE & wdata[pcs_pkg::CTL_UPDATE_BIT];
        end else if (vblank_rise) begin
            update_ff <= 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            soft_rst_ff <= pcs_pkg::RST_SOFT;
        end else if (srst_wr) begin
            soft_rst_ff <= wdata[pcs_pkg::SRST_BIT];
        end
    end

    // run moves only at frame start or when soft reset forces it low, so the enable never cuts a frame in half
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            run_ff <= pcs_pkg::RST_RUN_ENABLE;
        end else if (soft_rst_ff) begin
            run_ff <= 1'b0;
        end else if (vblank_rise) begin
            run_ff <= enable_ff;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            commit_ff <= 1'b0;
        end else begin
            commit_ff <= HAS_UPDATE & vblank_rise & update_ff & ~soft_rst_ff;
        end
    end
endmodule : pcs_stage_ctl

/* tb/pcs_apb_host.sv */
// apb host model that programs and services the register bank
`timescale 1ns/1ps
module pcs_apb_host (
    input  wire logic        mclk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [11:0]      paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
    end
    // request held until pready is sampled high or 16 access cycles pass, then released
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e, output bit ok);
        ok = 1'b0;
        @(posedge mclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        for (int i = 0; i < 16 && !ok; i++) begin
            @(posedge mclk);
            ok = (pready === 1'b1);
        end
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
    // service: find the source first, then clear so it can fire again
    task automatic isr(input logic [31:0] ic, output logic [31:0] st, output bit ok);
        logic [31:0] r;
        logic        e;
        xfer(1'b0, pcs_pkg::OFS_STATUS, 32'h0, st, e, ok);
        if (ok) xfer(1'b1, pcs_pkg::OFS_INT_CTRL, ic | 32'h2, r, e, ok);
    endtask : isr
endmodule : pcs_apb_host

/* tb/pcs_pipeline_regs_tb_top.sv */
// self-checking bench for the pipeline control and status register bank
`timescale 1ns/1ps
module pcs_pipeline_regs_tb_top;
    logic        mclk = 1'b0, rst = 1'b1, vblank_in = 1'b0, vs = 1'b0, vpol = 1'b0;
    logic        psel, penable, pwrite, pready, pslverr, bx, by, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, st;
    logic [10:0] tcols = 11'h000;
    logic [3:0]  run, hold, cmt, cmt_seen = 4'h0;
    logic [9:0]  meas [9];
    logic [9:0]  work [9];
    int          bad_count = 0, checked = 0, seed = 30432, shd [9];
    bit          ok;
    always #20 mclk = ~mclk;
    // commit pulses stand one cycle, so remember every stage that fired
    always @(posedge mclk) if (!rst) cmt_seen <= cmt_seen | cmt;
    pcs_apb_host host (.mclk(mclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    pcs_pipeline_regs dut (.mclk(mclk), .rst(rst), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .vblank_in(vblank_in), .det_vsync_seen(vs),
        .det_vblank_pol(vpol), .det_hblank_pol(1'b0), .det_total_rows(11'h000),
        .det_total_cols(tcols), .det_blank_rows(11'h000), .det_blank_cols(11'h000),
        .meas_timing(meas), .work_timing(work), .stage_run(run), .stage_hold(hold),
        .stage_commit(cmt), .bayer_phase_x(bx), .bayer_phase_y(by), .irq(irq));
    task automatic test_done();
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : test_done
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic ee, output logic [31:0] r);
        logic e;
        host.xfer(w, a, d, r, e, ok);
        if (!ok) begin
            bad_count++;
            test_done();
        end
        chk(32'(e), 32'(ee));
    endtask : acc
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        acc(1'b1, a, d, 1'b0, r);
    endtask : wr
    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] r;
        acc(1'b0, a, 32'h0, 1'b0, r);
        chk(r, exp);
    endtask : rdc
    // pin rise is seen about three cycles later; ten cycles covers the copy
    task automatic frame();
        vblank_in <= 1'b1;
        repeat (8) @(posedge mclk);
        vblank_in <= 1'b0;
        repeat (2) @(posedge mclk);
    endtask : frame
    task automatic chk_work(input bit vs_meas);
        for (int i = 0; i < 9; i++) chk(32'(work[i]), vs_meas ? 32'(meas[i]) : shd[i]);
    endtask : chk_work
    initial begin
        logic [31:0] r;
        for (int i = 0; i < 9; i++) meas[i] = 10'(i);
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        for (int s = 0; s < 4; s++) begin
            rdc(12'(s * 16), 32'h1);
            rdc(12'(s * 16 + 4), 32'h0);
        end
        rdc(pcs_pkg::OFS_STATUS, 32'h0);
        acc(1'b0, 12'hFFC, 32'h0, 1'b1, r);
        chk(r, 32'h0);
        $display("test reset values done");
        wr(12'h000, 32'h0);
        wr(12'h010, 32'h0);
        repeat (4) @(posedge mclk);
        chk(32'(run), 32'hF);
        frame();
        chk(32'(run), 32'hC);
        wr(12'h000, 32'h1);
        wr(12'h010, 32'h1);
        frame();
        chk(32'(run), 32'hF);
        $display("test run enable done");
        for (int i = 0; i < 9; i++) begin
            shd[i] = $random(seed) & (pcs_pkg::ROW_FIELDS[i] ? 32'h3FF : 32'h3FF);
            meas[i] <= 10'($random(seed));
            wr(pcs_pkg::OFS_TIMING_BASE + 12'(4 * i), shd[i]);
        end
        for (int i = 0; i < 9; i++) rdc(pcs_pkg::OFS_TIMING_BASE + 12'(4 * i), shd[i]);
        chk_work(1'b1);
        wr(pcs_pkg::OFS_PHASE, 32'h2);
        wr(12'h010, 32'h3);
        rdc(12'h010, 32'h3);
        wr(12'h030, 32'h3);
        rdc(12'h030, 32'h1);
        frame();
        chk_work(1'b0);
        chk({30'h0, by, bx}, 32'h2);
        chk(32'(cmt_seen), 32'h2);
        rdc(12'h010, 32'h1);
        meas[0] <= ~meas[0];
        repeat (2) @(posedge mclk);
        chk_work(1'b0);
        $display("test double buffer done");
        wr(pcs_pkg::OFS_INT_CTRL, 32'h401);
        vs <= 1'b1;
        @(posedge mclk);
        vs <= 1'b0;
        repeat (3) @(posedge mclk);
        chk(32'(irq), 32'h0);
        tcols <= 11'd1100;
        repeat (3) @(posedge mclk);
        chk(32'(irq), 32'h1);
        tcols <= 11'd5;
        rdc(pcs_pkg::OFS_STATUS, 32'h4500);
        host.isr(32'h401, st, ok);
        chk(st, 32'h4500);
        // irq drops at the clear edge; look once it has settled
        @(posedge mclk);
        chk(32'(irq), 32'h0);
        rdc(pcs_pkg::OFS_STATUS, 32'h0);
        rdc(pcs_pkg::OFS_INT_CTRL, 32'h401);
        vpol <= 1'b1;
        rdc(pcs_pkg::OFS_STATUS, 32'h800);
        chk(32'(irq), 32'h0);
        wr(12'h010, 32'h5);
        rdc(pcs_pkg::OFS_STATUS, 32'h0);
        $display("test status and interrupt done");
        wr(12'h014, 32'h1);
        repeat (2) @(posedge mclk);
        chk(32'(hold), 32'h2);
        chk(32'(run), 32'hD);
        chk_work(1'b1);
        rdc(pcs_pkg::OFS_INT_CTRL, 32'h0);
        rdc(12'h014, 32'h1);
        wr(12'h014, 32'h0);
        chk(32'(run), 32'hD);
        frame();
        chk(32'(run), 32'hF);
        $display("test soft reset done");
        test_done();
    end
endmodule : pcs_pipeline_regs_tb_top
